// file: include/dspwm_pkg.sv
// Summary of operation
// - Dual-slope symmetric mode runs when the waveform mode select is 8 or 9.
// - Count runs from 0x0000 up to TOP, then down to zero, repeatedly.
// - Non-inverting: clear on up-count match, set on down-count match; inverting reverses.
// - TOP is the capture value in mode 8, compare A in mode 9; direction turns there.
// - Count holds TOP for exactly one timer tick before decrementing.
// - Compare match flag sets on a timer tick while count equals that unit's active compare value.
// - Overflow flag sets at BOTTOM, in the tick that loads the active compare values.
// - Compare A or capture flag sets when count reaches TOP defined by that register.
// - Written compare values are buffered and moved to active registers at BOTTOM, or every clock while mode is not 8 or 9.
// - TOP must be at least every compare value; otherwise that unit never matches.
// - Output mode 2 gives non-inverted waveform, output mode 3 gives inverted waveform.
// - Compare output reaches the pin only when its direction bit selects output.
// - Period is two times prescale divisor times TOP clocks; divisors 1,8,64,256,1024.
// - Compare zero gives constant low, compare TOP gives high, non-inverted; inverted opposite.
// - Mode 9 with compare A output mode 1 toggles output A on each match.
// - Fully synchronous: the prescaled tick is a clock enable, not a clock.
// - Output mode 0 disconnects the compare output; pin follows normal port value.
// - Output mode 1 toggles only output A in mode 9; output B stays disconnected.
package dspwm_pkg;
    localparam logic [3:0] MODE_TOP_CAPTURE = 4'h8;
    localparam logic [3:0] MODE_TOP_CMPA = 4'h9;
    localparam logic [1:0] OUT_OFF = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_NONINV = 2'h2;
    localparam logic [1:0] OUT_INV = 2'h3;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] TOP_MIN = 16'h0003;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic WAVE_RST = 1'b0;
    // prescale select codes
    localparam logic [2:0] PRE_STOP = 3'h0;
    localparam logic [2:0] PRE_DIV1 = 3'h1;
    localparam logic [2:0] PRE_DIV8 = 3'h2;
    localparam logic [2:0] PRE_DIV64 = 3'h3;
    localparam logic [2:0] PRE_DIV256 = 3'h4;
    localparam logic [2:0] PRE_DIV1024 = 3'h5;
    // terminal counts, divisor minus one
    localparam logic [9:0] LIM_DIV1 = 10'h000;
    localparam logic [9:0] LIM_DIV8 = 10'h007;
    localparam logic [9:0] LIM_DIV64 = 10'h03f;
    localparam logic [9:0] LIM_DIV256 = 10'h0ff;
    localparam logic [9:0] LIM_DIV1024 = 10'h3ff;
    localparam logic [9:0] PRE_CNT_RST = 10'h000;
    localparam logic [9:0] PRE_CNT_STEP = 10'h001;
    // flag clear bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int FLG_CAP = 3;
    typedef enum logic {DIR_UP, DIR_DOWN} dspwm_dir_e;
endpackage : dspwm_pkg

// file: include/dspwm_tick_if.sv
`timescale 1ns/10ps
interface dspwm_tick_if;
    logic [2:0] sel;
    logic tick;
    modport src
    (
        input sel,
        output tick
    );
    modport snk
    (
        output sel,
        input tick
    );
endinterface : dspwm_tick_if

// file: logic/dspwm_prescale.sv
`timescale 1ns/10ps
module dspwm_prescale
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // tick to the counter
    dspwm_tick_if.src tk
);
    logic [9:0] div_cnt_r;
    logic tick_r;
    logic run;
    logic [9:0] lim;

    always_comb
    begin
        run = 1'b1;
        lim = dspwm_pkg::LIM_DIV1;
        if (tk.sel == dspwm_pkg::PRE_DIV1)
            lim = dspwm_pkg::LIM_DIV1;
        else if (tk.sel == dspwm_pkg::PRE_DIV8)
            lim = dspwm_pkg::LIM_DIV8;
        else if (tk.sel == dspwm_pkg::PRE_DIV64)
            lim = dspwm_pkg::LIM_DIV64;
        else if (tk.sel == dspwm_pkg::PRE_DIV256)
            lim = dspwm_pkg::LIM_DIV256;
        else if (tk.sel == dspwm_pkg::PRE_DIV1024)
            lim = dspwm_pkg::LIM_DIV1024;
        else
            run = 1'b0;
    end

    // tick is an enable on i_clk, never a clock of its own
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            div_cnt_r <= dspwm_pkg::PRE_CNT_RST;
            tick_r <= 1'b0;
        end
        else if (!run)
        begin
            div_cnt_r <= dspwm_pkg::PRE_CNT_RST;
            tick_r <= 1'b0;
        end
        else if (div_cnt_r >= lim)
        begin
            div_cnt_r <= dspwm_pkg::PRE_CNT_RST;
            tick_r <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + dspwm_pkg::PRE_CNT_STEP;
            tick_r <= 1'b0;
        end
    end

    assign tk.tick = tick_r;

    chk_div8_spacing: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (tick_r && tk.sel == dspwm_pkg::PRE_DIV8) |=> (!tick_r || tk.sel != dspwm_pkg::PRE_DIV8) [*7])
        else $error("tick spacing wrong at divide by 8");
endmodule : dspwm_prescale

// file: logic/dspwm_top.sv
`timescale 1ns/10ps
module dspwm_top
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // mode configuration
    input wire logic [3:0] i_waveform_mode_sel,
    input wire logic [2:0] i_prescale_sel,
    input wire logic [1:0] i_compare_a_out_mode,
    input wire logic [1:0] i_compare_b_out_mode,
    // value writes
    input wire logic i_compare_a_wr,
    input wire logic [15:0] i_compare_a_wdata,
    input wire logic i_compare_b_wr,
    input wire logic [15:0] i_compare_b_wdata,
    input wire logic [15:0] i_capture_value,
    // port control
    input wire logic i_pin_direction_a,
    input wire logic i_pin_direction_b,
    input wire logic i_port_a,
    input wire logic i_port_b,
    // flag clear strobes
    input wire logic [3:0] i_flag_clr,
    // counter and waveforms
    output logic [15:0] o_timer_count,
    output logic o_compare_a_out,
    output logic o_compare_b_out,
    // pins
    output logic o_pin_a,
    output logic o_pin_a_oe,
    output logic o_pin_b,
    output logic o_pin_b_oe,
    // status flags
    output logic o_overflow_flag,
    output logic o_compare_a_match_flag,
    output logic o_compare_b_match_flag,
    output logic o_capture_flag
);
    logic [15:0] timer_cnt_r;
    dspwm_pkg::dspwm_dir_e dir_r;
    logic [15:0] cmp_a_buf_r;
    logic [15:0] cmp_b_buf_r;
    logic [15:0] cmp_a_act_r;
    logic [15:0] cmp_b_act_r;
    logic cmp_a_out_r;
    logic cmp_b_out_r;
    logic pin_a_r;
    logic pin_a_oe_r;
    logic pin_b_r;
    logic pin_b_oe_r;
    logic ovf_flag_r;
    logic cmpa_flag_r;
    logic cmpb_flag_r;
    logic cap_flag_r;
    logic mode_ok;
    logic mode_cmpa_top;
    logic mode_cap_top;
    logic tick;
    logic run_tick;
    logic [15:0] top;
    logic bottom_ev;
    logic top_ev;
    logic eff_down;
    logic match_a;
    logic match_b;

    dspwm_tick_if tk();

    assign tk.sel = i_prescale_sel;
    assign tick = tk.tick;

    dspwm_prescale u_prescale
    (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tk(tk)
    );

    function automatic logic unit_match(input logic en, input logic [15:0] cnt, input logic [15:0] val);
        unit_match = en && (cnt == val);
    endfunction : unit_match

    // match at TOP counts as down, at BOTTOM as up: gives steady levels at the extremes
    function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic hit,
                                       input logic down, input logic tog_ok);
        wave_next = cur;
        if (hit)
        begin
            if (om == dspwm_pkg::OUT_NONINV)
                wave_next = down;
            else if (om == dspwm_pkg::OUT_INV)
                wave_next = !down;
            else if (om == dspwm_pkg::OUT_TOGGLE && tog_ok)
                wave_next = !cur;
        end
    endfunction : wave_next

    function automatic logic pin_linked(input logic [1:0] om, input logic tog_ok);
        pin_linked = (om == dspwm_pkg::OUT_NONINV) || (om == dspwm_pkg::OUT_INV)
                     || (om == dspwm_pkg::OUT_TOGGLE && tog_ok);
    endfunction : pin_linked

    // set wins over a clear in the same cycle
    function automatic logic sticky(input logic cur, input logic clr, input logic set);
        sticky = (cur && !clr) || set;
    endfunction : sticky

    assign mode_cap_top = (i_waveform_mode_sel == dspwm_pkg::MODE_TOP_CAPTURE);
    assign mode_cmpa_top = (i_waveform_mode_sel == dspwm_pkg::MODE_TOP_CMPA);
    assign mode_ok = mode_cap_top || mode_cmpa_top;
    assign top = mode_cmpa_top ? cmp_a_act_r : i_capture_value;
    assign run_tick = tick && mode_ok;
    assign bottom_ev = run_tick && (timer_cnt_r == dspwm_pkg::COUNT_BOTTOM);
    assign top_ev = run_tick && (dir_r == dspwm_pkg::DIR_UP) && (timer_cnt_r == top);
    assign eff_down = (timer_cnt_r == top)
                      || (dir_r == dspwm_pkg::DIR_DOWN && timer_cnt_r != dspwm_pkg::COUNT_BOTTOM);
    // a compare value above TOP is never reached, so it never matches
    assign match_a = unit_match(run_tick, timer_cnt_r, cmp_a_act_r);
    assign match_b = unit_match(run_tick, timer_cnt_r, cmp_b_act_r);

    // dual-slope counter; top below 0x0003 is software misuse and not guarded
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            timer_cnt_r <= dspwm_pkg::COUNT_RST;
            dir_r <= dspwm_pkg::DIR_UP;
        end
        else if (!mode_ok)
        begin
            timer_cnt_r <= dspwm_pkg::COUNT_BOTTOM;
            dir_r <= dspwm_pkg::DIR_UP;
        end
        else if (tick)
        begin
            case (dir_r)
                dspwm_pkg::DIR_UP:
                begin
                    if (timer_cnt_r == top)
                    begin
                        timer_cnt_r <= timer_cnt_r - dspwm_pkg::COUNT_STEP;
                        dir_r <= dspwm_pkg::DIR_DOWN;
                    end
                    else
                        timer_cnt_r <= timer_cnt_r + dspwm_pkg::COUNT_STEP;
                end
                dspwm_pkg::DIR_DOWN:
                begin
                    if (timer_cnt_r == dspwm_pkg::COUNT_BOTTOM)
                    begin
                        timer_cnt_r <= dspwm_pkg::COUNT_BOTTOM + dspwm_pkg::COUNT_STEP;
                        dir_r <= dspwm_pkg::DIR_UP;
                    end
                    else
                        timer_cnt_r <= timer_cnt_r - dspwm_pkg::COUNT_STEP;
                end
                default:
                begin
                    timer_cnt_r <= dspwm_pkg::COUNT_BOTTOM;
                    dir_r <= dspwm_pkg::DIR_UP;
                end
            endcase
        end
    end

    // compare buffers take software writes at any time
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cmp_a_buf_r <= dspwm_pkg::CMP_RST;
            cmp_b_buf_r <= dspwm_pkg::CMP_RST;
        end
        else
        begin
            if (i_compare_a_wr)
                cmp_a_buf_r <= i_compare_a_wdata;
            if (i_compare_b_wr)
                cmp_b_buf_r <= i_compare_b_wdata;
        end
    end

    // loading only at BOTTOM keeps both slopes of a period the same length
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cmp_a_act_r <= dspwm_pkg::CMP_RST;
            cmp_b_act_r <= dspwm_pkg::CMP_RST;
        end
        else if (bottom_ev || !mode_ok)
        begin
            cmp_a_act_r <= cmp_a_buf_r;
            cmp_b_act_r <= cmp_b_buf_r;
        end
    end

    // waveform registers
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cmp_a_out_r <= dspwm_pkg::WAVE_RST;
            cmp_b_out_r <= dspwm_pkg::WAVE_RST;
        end
        else
        begin
            cmp_a_out_r <= wave_next(cmp_a_out_r, i_compare_a_out_mode, match_a, eff_down,
                                     mode_cmpa_top);
            cmp_b_out_r <= wave_next(cmp_b_out_r, i_compare_b_out_mode, match_b, eff_down,
                                     1'b0);
        end
    end

    // pin stage lags the waveform register by one clock
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_a_r <= 1'b0;
            pin_a_oe_r <= 1'b0;
            pin_b_r <= 1'b0;
            pin_b_oe_r <= 1'b0;
        end
        else
        begin
            pin_a_oe_r <= i_pin_direction_a;
            pin_b_oe_r <= i_pin_direction_b;
            if (mode_ok && pin_linked(i_compare_a_out_mode, mode_cmpa_top))
                pin_a_r <= cmp_a_out_r;
            else
                pin_a_r <= i_port_a;
            if (mode_ok && pin_linked(i_compare_b_out_mode, 1'b0))
                pin_b_r <= cmp_b_out_r;
            else
                pin_b_r <= i_port_b;
        end
    end

    // status flags
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ovf_flag_r <= 1'b0;
            cmpa_flag_r <= 1'b0;
            cmpb_flag_r <= 1'b0;
            cap_flag_r <= 1'b0;
        end
        else
        begin
            ovf_flag_r <= sticky(ovf_flag_r, i_flag_clr[dspwm_pkg::FLG_OVF], bottom_ev);
            cmpa_flag_r <= sticky(cmpa_flag_r, i_flag_clr[dspwm_pkg::FLG_CMPA],
                                  match_a || (top_ev && mode_cmpa_top));
            cmpb_flag_r <= sticky(cmpb_flag_r, i_flag_clr[dspwm_pkg::FLG_CMPB], match_b);
            cap_flag_r <= sticky(cap_flag_r, i_flag_clr[dspwm_pkg::FLG_CAP],
                                 top_ev && mode_cap_top);
        end
    end

    assign o_timer_count = timer_cnt_r;
    assign o_compare_a_out = cmp_a_out_r;
    assign o_compare_b_out = cmp_b_out_r;
    assign o_pin_a = pin_a_r;
    assign o_pin_a_oe = pin_a_oe_r;
    assign o_pin_b = pin_b_r;
    assign o_pin_b_oe = pin_b_oe_r;
    assign o_overflow_flag = ovf_flag_r;
    assign o_compare_a_match_flag = cmpa_flag_r;
    assign o_compare_b_match_flag = cmpb_flag_r;
    assign o_capture_flag = cap_flag_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    chk_mode_idle: assert property (!mode_ok |=> timer_cnt_r == dspwm_pkg::COUNT_BOTTOM)
        else $error("counter not parked outside the dual-slope mode");

    chk_up_step: assert property (
        (run_tick && dir_r == dspwm_pkg::DIR_UP && timer_cnt_r != top)
        |=> timer_cnt_r == $past(timer_cnt_r) + dspwm_pkg::COUNT_STEP)
        else $error("up-count step wrong");

    chk_top_turn: assert property (top_ev |=>
        (dir_r == dspwm_pkg::DIR_DOWN && timer_cnt_r == $past(timer_cnt_r) - dspwm_pkg::COUNT_STEP))
        else $error("direction did not turn at TOP");

    chk_bottom_turn: assert property (
        (run_tick && dir_r == dspwm_pkg::DIR_DOWN && timer_cnt_r == dspwm_pkg::COUNT_BOTTOM)
        |=> (dir_r == dspwm_pkg::DIR_UP && timer_cnt_r == dspwm_pkg::COUNT_STEP))
        else $error("direction did not turn at BOTTOM");

    chk_tick_enable: assert property ((mode_ok && !tick) |=> (!mode_ok || $stable(timer_cnt_r)))
        else $error("counter moved without a tick");

    chk_ovf_load: assert property (bottom_ev |=>
        (ovf_flag_r && cmp_a_act_r == $past(cmp_a_buf_r) && cmp_b_act_r == $past(cmp_b_buf_r)))
        else $error("BOTTOM did not load compare values and set overflow");

    chk_buf_hold: assert property ((mode_ok && !bottom_ev) |=>
        ($stable(cmp_a_act_r) && $stable(cmp_b_act_r)))
        else $error("active compare changed away from BOTTOM");

    chk_match_flag: assert property ((run_tick && timer_cnt_r == cmp_b_act_r) |=> cmpb_flag_r)
        else $error("compare B flag missing on match");

    chk_noninv_up: assert property (
        (match_b && i_compare_b_out_mode == dspwm_pkg::OUT_NONINV && !eff_down) |=> !cmp_b_out_r)
        else $error("non-inverted output not cleared on up match");

    chk_inv_down: assert property (
        (match_a && i_compare_a_out_mode == dspwm_pkg::OUT_INV && eff_down) |=> !cmp_a_out_r)
        else $error("inverted output not cleared on down match");

    chk_extreme_top: assert property (
        (match_a && i_compare_a_out_mode == dspwm_pkg::OUT_NONINV && timer_cnt_r == top) |=> cmp_a_out_r)
        else $error("match at TOP did not give high level");

    chk_toggle_a: assert property (
        (match_a && mode_cmpa_top && i_compare_a_out_mode == dspwm_pkg::OUT_TOGGLE)
        |=> cmp_a_out_r != $past(cmp_a_out_r))
        else $error("compare A did not toggle");

    chk_top_flags: assert property (top_ev |=> ($past(mode_cap_top) ? cap_flag_r : cmpa_flag_r))
        else $error("TOP flag not set");

    chk_pin_dir: assert property (1'b1 |=>
        (o_pin_a_oe == $past(i_pin_direction_a) && o_pin_b_oe == $past(i_pin_direction_b)))
        else $error("pin enable does not follow direction bit");

    chk_pin_disc: assert property (
        (i_compare_b_out_mode == dspwm_pkg::OUT_OFF || i_compare_b_out_mode == dspwm_pkg::OUT_TOGGLE)
        |=> o_pin_b == $past(i_port_b))
        else $error("disconnected pin B not under port control");

    chk_flag_set_wins: assert property ((bottom_ev && i_flag_clr[dspwm_pkg::FLG_OVF]) |=> ovf_flag_r)
        else $error("overflow lost against a clear");

    cov_cap_top: cover property (top_ev && mode_cap_top);
    cov_cmpa_toggle: cover property (match_a && mode_cmpa_top && i_compare_a_out_mode == dspwm_pkg::OUT_TOGGLE);
    cov_noninv_pwm: cover property (match_b && i_compare_b_out_mode == dspwm_pkg::OUT_NONINV ##[1:1000] match_b);
    cov_ovf_clear_race: cover property (bottom_ev && i_flag_clr[dspwm_pkg::FLG_OVF]);
endmodule : dspwm_top

// file: bench/dspwm_load.sv
`timescale 1ns/10ps
module dspwm_load
(
    // pin as driven by the block
    input wire logic i_drive,
    input wire logic i_oe,
    // level that the load sees
    output logic o_level
);
    // weak pull-down on the load: a released pin reads low, never the last value
    assign o_level = i_oe ? i_drive : 1'b0;
endmodule : dspwm_load

// file: bench/test_dual_slope_symmetric_pwm.sv
`timescale 1ns/10ps
module test_dual_slope_symmetric_pwm;
    typedef struct {logic [3:0] md; logic [2:0] ps; int n; logic [15:0] top; logic [15:0] ca; logic [15:0] cb;
        logic [1:0] am; logic [1:0] bm; logic da; logic db; logic [31:0] ea; logic [31:0] eb;} dspwm_row_s;
    logic i_clk;
    logic i_rstn;
    logic [3:0] md;
    logic [2:0] ps;
    logic [1:0] am;
    logic [1:0] bm;
    logic awr;
    logic bwr;
    logic [15:0] awd;
    logic [15:0] bwd;
    logic [15:0] cap;
    logic dira;
    logic dirb;
    logic pa;
    logic pb;
    logic [3:0] clr;
    logic [15:0] cnt;
    logic ca_out;
    logic cb_out;
    logic pin_a;
    logic pin_a_oe;
    logic pin_b;
    logic pin_b_oe;
    logic ovf;
    logic fa;
    logic fb;
    logic fc;
    logic lvl_a;
    logic lvl_b;
    int errors;
    int checks_done;
    int w;
    logic [31:0] ha;
    logic [31:0] hb;
    logic [31:0] z;
    logic [31:0] t;
    logic [15:0] mx;
    // software keeps TOP at 3 or more; TOP is the capture value in mode 8 rows, compare A in mode 9 rows
    dspwm_row_s rows [8] = '{
        '{4'h8, 3'h1, 1, 16'h000a, 16'h0004, 16'h0007, 2'h2, 2'h3, 1'b1, 1'b1, 32'd16, 32'd12},
        '{4'h8, 3'h1, 1, 16'h000a, 16'h0000, 16'h000a, 2'h2, 2'h2, 1'b1, 1'b1, 32'd0, 32'd40},
        '{4'h8, 3'h1, 1, 16'h000a, 16'h0000, 16'h000a, 2'h3, 2'h3, 1'b1, 1'b1, 32'd40, 32'd0},
        '{4'h9, 3'h1, 1, 16'h0006, 16'h0006, 16'h0002, 2'h1, 2'h2, 1'b1, 1'b1, 32'd12, 32'd8},
        '{4'h9, 3'h2, 8, 16'h0005, 16'h0005, 16'h0003, 2'h2, 2'h2, 1'b1, 1'b0, 32'd160, 32'd0},
        '{4'h8, 3'h3, 64, 16'h0003, 16'h0001, 16'h0002, 2'h0, 2'h1, 1'b1, 1'b1, 32'd768, 32'd768},
        '{4'h8, 3'h4, 256, 16'h0003, 16'h0000, 16'h0000, 2'h2, 2'h3, 1'b1, 1'b1, 32'd0, 32'd3072},
        '{4'h8, 3'h5, 1024, 16'h0003, 16'h0003, 16'h0001, 2'h2, 2'h2, 1'b1, 1'b1, 32'd12288, 32'd4096}};

    dspwm_top u_dspwm_top
    (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_waveform_mode_sel(md), .i_prescale_sel(ps),
        .i_compare_a_out_mode(am), .i_compare_b_out_mode(bm), .i_compare_a_wr(awr), .i_compare_a_wdata(awd),
        .i_compare_b_wr(bwr), .i_compare_b_wdata(bwd), .i_capture_value(cap), .i_pin_direction_a(dira),
        .i_pin_direction_b(dirb), .i_port_a(pa), .i_port_b(pb), .i_flag_clr(clr), .o_timer_count(cnt),
        .o_compare_a_out(ca_out), .o_compare_b_out(cb_out), .o_pin_a(pin_a), .o_pin_a_oe(pin_a_oe),
        .o_pin_b(pin_b), .o_pin_b_oe(pin_b_oe), .o_overflow_flag(ovf), .o_compare_a_match_flag(fa),
        .o_compare_b_match_flag(fb), .o_capture_flag(fc)
    );
    dspwm_load u_dspwm_load_a (.i_drive(pin_a), .i_oe(pin_a_oe), .o_level(lvl_a));
    dspwm_load u_dspwm_load_b (.i_drive(pin_b), .i_oe(pin_b_oe), .o_level(lvl_b));

    task step(input int k);
        repeat (k)
        begin
            @(posedge i_clk);
            #1;
        end
    endtask : step

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [15:0] b);
        awr = 1'b1;
        bwr = 1'b1;
        awd = a;
        bwd = b;
        step(1);
        awr = 1'b0;
        bwr = 1'b0;
        step(1);
    endtask : wr

    // bounded wait for a count value; a miss counts as a mismatch
    task wait_count(input logic [15:0] v);
        int k;
        k = 0;
        while (cnt !== v && k < 5000)
        begin
            step(1);
            k++;
        end
        if (k == 5000)
            errors++;
    endtask : wait_count

    task wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end

    initial
    begin
        {i_rstn, awr, bwr, dira, dirb, pa, pb} = 7'h0f;
        {md, ps, am, bm, clr} = 15'h0000;
        {awd, bwd, cap} = 48'h0;
        step(12);
        chk("count in reset", cnt, 16'h0000);
        chk("flags in reset", {ovf, fa, fb, fc}, 4'h0);
        i_rstn = 1'b1;
        foreach (rows[i])
        begin
            md = 4'h0;
            step(1);
            wr(rows[i].ca, rows[i].cb);
            {cap, ps, am, bm, dira, dirb} = {rows[i].top, rows[i].ps, rows[i].am, rows[i].bm, rows[i].da, rows[i].db};
            md = rows[i].md;
            w = 4 * int'(rows[i].top) * rows[i].n;
            step(w + 8);
            {ha, hb, z, t, mx} = '0;
            repeat (w)
            begin
                ha += lvl_a;
                hb += lvl_b;
                z += 32'(cnt === 16'h0000);
                t += 32'(cnt === rows[i].top);
                if (cnt > mx)
                    mx = cnt;
                step(1);
            end
            chk("pin a highs", ha, rows[i].ea);
            chk("pin b highs", hb, rows[i].eb);
            chk("bottom cycles", z, 32'(2 * rows[i].n));
            chk("top cycles", t, 32'(2 * rows[i].n));
            chk("peak count", mx, rows[i].top);
        end
        md = 4'h0;
        step(1);
        wr(16'h0004, 16'h0014);
        {cap, ps, am, bm} = {16'h000a, dspwm_pkg::PRE_DIV1, dspwm_pkg::OUT_NONINV, dspwm_pkg::OUT_NONINV};
        md = dspwm_pkg::MODE_TOP_CAPTURE;
        step(30);
        clr = 4'hf;
        step(1);
        clr = 4'h0;
        step(25);
        chk("overflow flag", ovf, 1'b1);
        chk("capture flag", fc, 1'b1);
        chk("match a flag", fa, 1'b1);
        chk("match b flag", fb, 1'b0);
        md = 4'h0;
        step(1);
        wr(16'h0014, 16'h0005);
        md = dspwm_pkg::MODE_TOP_CMPA;
        step(50);
        wait_count(16'h0000);
        wait_count(16'h0001);
        // new value mid-period must wait for the next bottom
        bwr = 1'b1;
        bwd = 16'h000f;
        step(1);
        bwr = 1'b0;
        wait_count(16'h0014);
        wait_count(16'h000a);
        chk("b out old value", cb_out, 1'b0);
        wait_count(16'h0000);
        wait_count(16'h0014);
        wait_count(16'h000a);
        chk("b out new value", cb_out, 1'b1);
        // stopping the prescaler must freeze the count
        ps = dspwm_pkg::PRE_STOP;
        step(2);
        mx = cnt;
        step(40);
        chk("count held when stopped", cnt, mx);
        i_rstn = 1'b0;
        md = 4'h0;
        step(1);
        chk("count after reset", cnt, 16'h0000);
        chk("outs after reset", {ca_out, cb_out, ovf, fa}, 4'h0);
        i_rstn = 1'b1;
        step(2);
        chk("count after release", cnt, 16'h0000);
        wrap_up();
    end
endmodule : test_dual_slope_symmetric_pwm
